// >>> design/samp_path_consts.svh
/*
  Offsets, reset values, field encodings and sizes of the sample path.
  Assumes inclusion by bare name from the modules and the bench.
*/
`ifndef SAMP_PATH_CONSTS_SVH
`define SAMP_PATH_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL    8'h00
`define OFS_SPR     8'h04
`define OFS_RPA     8'h08
`define OFS_SCPR    8'h0C
`define OFS_MAPIDX  8'h10
`define OFS_MAPDAT  8'h14
`define OFS_STATUS  8'h18

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SPR_RST     11'h400
`define SPR_MAX     11'h400
`define RPA_RST     24'h000001
`define SCPR_RST    17'h10000
`define SCPR_MAX    17'h10000
`define ACC_DEPTH   1024
`define MAP_WORDS   4096

// ----------------------------------------------------------------
// Low bit sources and resolutions
// ----------------------------------------------------------------
`define SRC_DEFAULT 2'h0
`define SRC_TRIG    2'h1
`define SRC_AUX2    2'h2
`define SRC_AUX1    2'h3
`define RES_14      2'h0
`define RES_12      2'h1
`define RES_8       2'h2

`endif

// >>> design/samp_path_pkg.sv
/*
  Types of the sample path: control word layout, front end bundle, states.
  Assumes the constants header is on the include path.
*/
package samp_path_pkg;

  // Control word, bit 0 upward: avg, signed, skip, pad, src0, src1, res
  typedef struct packed {
    logic [1:0] res;
    logic [1:0] low_bit1_source;
    logic [1:0] low_bit0_source;
    logic       pad;
    logic       skip_on;
    logic       avg_signed;
    logic       avg_on;
  } cfg_t;

  typedef struct packed {
    logic [13:0] code_a;
    logic [13:0] code_b;
    logic        valid;
    logic        trigger;
    logic        low_bit_src_trigger_in;
    logic        aux1;
    logic        aux2;
  } front_t;

  typedef enum logic [1:0] {ST_IDLE, ST_REC, ST_DUMP} state_t;

endpackage : samp_path_pkg

// >>> design/samp_lowbit_fmt.sv
/*
  Builds a 16-bit sample word from a converter code and low bit sources.
  Assumes code right aligned; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "samp_path_consts.svh"

module samp_lowbit_fmt import samp_path_pkg::*; (
  input  wire logic [13:0] code,
  input  wire logic [1:0]  res,
  input  wire logic [1:0]  src0,
  input  wire logic [1:0]  src1,
  input  wire logic        trig_lvl,
  input  wire logic        aux1,
  input  wire logic        aux2,
  output logic      [15:0] sample
);

  function automatic logic pick(input logic [1:0] s, input logic t,
                                input logic a1, input logic a2);
    unique case (s)
      `SRC_DEFAULT: pick = 1'b0;
      `SRC_TRIG:    pick = t;
      `SRC_AUX2:    pick = a2;
      `SRC_AUX1:    pick = a1;
    endcase
  endfunction : pick

  always_comb begin
    // Code in the top bits, spare bits zero
    unique case (res)
      `RES_12: sample = {code[11:0], 4'h0};
      `RES_8:  sample = {code[7:0], 8'h00};
      default: sample = {code, 2'h0};
    endcase
    sample[0] = pick(src0, trig_lvl, aux1, aux2);
    sample[1] = pick(src1, trig_lvl, aux1, aux2);
  end

endmodule : samp_lowbit_fmt
`default_nettype wire

// >>> design/samp_path_top.sv
/*
  Acquisition sample path: low bit fill, record averaging, sample skipping,
  AHB-Lite register slave. Assumes one clock; front end inputs synchronous.
*/
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "samp_path_consts.svh"

module samp_path_top import samp_path_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire front_t      fe,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [31:0] out_data,
  output logic             out_last,
  output logic             rec_busy
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  cfg_t        cfg_reg;
  logic [10:0] spr_reg;
  logic [23:0] rpa_reg;
  logic [16:0] scpr_reg;
  logic [11:0] map_idx_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_val;
  logic [15:0] keep_map [`MAP_WORDS];
  state_t      st_reg;
  logic [23:0] rec_cnt_reg;

  wire take = hsel & htrans[1] & hready;
  wire lo   = (haddr[31:8] == 24'h0) & (hsize == 3'h2);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (lo) begin
      unique case (haddr[7:0])
        `OFS_CTRL:   rd_val = {22'h0, cfg_reg};
        `OFS_SPR:    rd_val = {21'h0, spr_reg};
        `OFS_RPA:    rd_val = {8'h00, rpa_reg};
        `OFS_SCPR:   rd_val = {15'h0, scpr_reg};
        `OFS_MAPIDX: rd_val = {20'h0, map_idx_reg};
        `OFS_STATUS: rd_val = {6'h0, st_reg, rec_cnt_reg};
        default:     rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'hFF;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take & hwrite & lo;
      if (take) begin
        wr_addr_reg <= haddr[7:0];
        hrdata_reg  <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg  <= '0;
      spr_reg  <= `SPR_RST;
      rpa_reg  <= `RPA_RST;
      scpr_reg <= `SCPR_RST;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `OFS_CTRL: begin
          cfg_reg     <= cfg_t'(hwdata[9:0]);
          cfg_reg.pad <= 1'b0;
        end
        `OFS_SPR:
          spr_reg <= (hwdata > 32'(`SPR_MAX)) ? `SPR_MAX : hwdata[10:0];
        `OFS_RPA:  rpa_reg <= hwdata[23:0];
        `OFS_SCPR:
          scpr_reg <= (hwdata > 32'(`SCPR_MAX)) ? `SCPR_MAX : hwdata[16:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      map_idx_reg <= 12'h000;
    else if (wr_pend_reg && wr_addr_reg == `OFS_MAPIDX)
      map_idx_reg <= hwdata[11:0];
    else if (wr_pend_reg && wr_addr_reg == `OFS_MAPDAT)
      map_idx_reg <= map_idx_reg + 12'h001;
  end

  always_ff @(posedge hclk) begin
    if (wr_pend_reg && wr_addr_reg == `OFS_MAPDAT)
      keep_map[map_idx_reg] <= hwdata[15:0];
  end

  // ----------------------------------------------------------------
  // Sample formatting
  // ----------------------------------------------------------------
  logic [15:0] fa;
  logic [15:0] fb;

  samp_lowbit_fmt u_fmt_a (
    .code     (fe.code_a),
    .res      (cfg_reg.res),
    .src0     (cfg_reg.low_bit0_source),
    .src1     (cfg_reg.low_bit1_source),
    .trig_lvl (fe.low_bit_src_trigger_in),
    .aux1     (fe.aux1),
    .aux2     (fe.aux2),
    .sample   (fa)
  );

  samp_lowbit_fmt u_fmt_b (
    .code     (fe.code_b),
    .res      (cfg_reg.res),
    .src0     (cfg_reg.low_bit0_source),
    .src1     (cfg_reg.low_bit1_source),
    .trig_lvl (fe.low_bit_src_trigger_in),
    .aux1     (fe.aux1),
    .aux2     (fe.aux2),
    .sample   (fb)
  );

  function automatic logic [31:0] widen(input logic [15:0] s, input logic sg);
    widen = {{16{sg & s[15]}}, s};
  endfunction : widen

  // ----------------------------------------------------------------
  // Record engine
  // ----------------------------------------------------------------
  logic [15:0] clk_idx_reg;
  logic [10:0] samp_idx_reg;
  logic [11:0] wcnt_reg;
  logic [31:0] acc_a [`ACC_DEPTH];
  logic [31:0] acc_b [`ACC_DEPTH];

  // Map word bit 0 is the first clock of each group of sixteen
  wire map_bit  = keep_map[clk_idx_reg[15:4]][clk_idx_reg[3:0]];
  wire keep     = !cfg_reg.skip_on | map_bit;
  wire samp_ok  = fe.valid & (st_reg == ST_REC);
  wire kept     = samp_ok & keep;
  wire rec_end  = samp_ok & (cfg_reg.skip_on ?
                  ({1'b0, clk_idx_reg} == scpr_reg - 17'h1) :
                  (samp_idx_reg == spr_reg - 11'h1));
  wire last_rec = (rec_cnt_reg + 24'h1) >= rpa_reg;
  wire raw_kept = kept & !cfg_reg.avg_on;
  wire [11:0] total = {spr_reg, 1'b0};
  wire dump_load = (st_reg == ST_DUMP) & (!out_valid | out_ready) & (wcnt_reg != total);
  wire dump_done = (st_reg == ST_DUMP) & (!out_valid | out_ready) & (wcnt_reg == total);
  // Extra kept samples beyond the record length are not accumulated
  wire acc_wr   = kept & cfg_reg.avg_on & (samp_idx_reg < spr_reg);
  wire [9:0]  acc_ix = samp_idx_reg[9:0];
  wire [31:0] inc_a  = widen(fa, cfg_reg.avg_signed);
  wire [31:0] inc_b  = widen(fb, cfg_reg.avg_signed);
  wire first_rec = (rec_cnt_reg == 24'h0);
  wire [9:0] acc_rd_ix = wcnt_reg[10:1];

  assign rec_busy = (st_reg != ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      st_reg <= ST_IDLE;
    else begin
      unique case (st_reg)
        ST_IDLE: if (fe.trigger) st_reg <= ST_REC;
        ST_REC:  if (rec_end)
                   st_reg <= (cfg_reg.avg_on && last_rec) ? ST_DUMP : ST_IDLE;
        ST_DUMP: if (dump_done) st_reg <= ST_IDLE;
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_idx_reg  <= 16'h0000;
      samp_idx_reg <= 11'h000;
    end else if (st_reg != ST_REC || rec_end) begin
      clk_idx_reg  <= 16'h0000;
      samp_idx_reg <= 11'h000;
    end else if (samp_ok) begin
      clk_idx_reg <= clk_idx_reg + 16'h0001;
      if (keep)
        samp_idx_reg <= samp_idx_reg + 11'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rec_cnt_reg <= 24'h000000;
    else if (!cfg_reg.avg_on)
      rec_cnt_reg <= 24'h000000;
    else if (rec_end)
      rec_cnt_reg <= last_rec ? 24'h000000 : rec_cnt_reg + 24'h000001;
  end

  always_ff @(posedge hclk) begin
    if (acc_wr) begin
      acc_a[acc_ix] <= (first_rec ? 32'h0000_0000 : acc_a[acc_ix]) + inc_a;
      acc_b[acc_ix] <= (first_rec ? 32'h0000_0000 : acc_b[acc_ix]) + inc_b;
    end
  end

  // ----------------------------------------------------------------
  // Output stream
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wcnt_reg <= 12'h000;
    else if (st_reg != ST_DUMP)
      wcnt_reg <= 12'h000;
    else if (dump_load)
      wcnt_reg <= wcnt_reg + 12'h001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_data  <= 32'h0000_0000;
      out_last  <= 1'b0;
    end else if (raw_kept) begin
      out_valid <= 1'b1;
      out_data  <= {fb, fa};
      out_last  <= rec_end;
    end else if (dump_load) begin
      out_valid <= 1'b1;
      // Word bit 7:0 is the first byte on the host side
      out_data  <= wcnt_reg[0] ? acc_b[wcnt_reg[10:1]] : acc_a[wcnt_reg[10:1]];
      out_last  <= (wcnt_reg == total - 12'h001);
    end else if (out_ready || st_reg != ST_DUMP) begin
      out_valid <= 1'b0;
      out_last  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_raw_code_top: assert property (
    raw_kept && cfg_reg.res == `RES_14 |=> out_data[15:2] == $past(fe.code_a))
    else $error("raw sample code not in top bits");
  chk_raw_low_zero: assert property (
    raw_kept && cfg_reg.low_bit0_source == `SRC_DEFAULT &&
    cfg_reg.low_bit1_source == `SRC_DEFAULT |=> out_data[1:0] == 2'b00)
    else $error("spare low bits not zero");
  chk_low_trig_src: assert property (
    raw_kept && cfg_reg.low_bit0_source == `SRC_TRIG |=>
    out_data[0] == $past(fe.low_bit_src_trigger_in))
    else $error("low bit 0 not trigger level");
  chk_low_aux_src: assert property (
    raw_kept && cfg_reg.low_bit1_source == `SRC_AUX1 &&
    cfg_reg.low_bit0_source == `SRC_AUX2 |=>
    out_data[1] == $past(fe.aux1) && out_data[0] == $past(fe.aux2))
    else $error("low bit sources mixed up");
  chk_dump_after_n: assert property (
    rec_end && cfg_reg.avg_on |=> (st_reg == ST_DUMP) == $past(last_rec))
    else $error("dump not tied to record count");
  chk_dump_order: assert property (
    dump_load |=> out_data == ($past(wcnt_reg[0]) ? $past(acc_b[acc_rd_ix]) : $past(acc_a[acc_rd_ix])))
    else $error("dump not alternating A and B");
  chk_dump_length: assert property (
    dump_done && total != 12'h000 |-> out_valid && out_last)
    else $error("dump length wrong");
  chk_skip_drop: assert property (
    samp_ok && cfg_reg.skip_on && !map_bit && !cfg_reg.avg_on && !dump_load |=> !out_valid)
    else $error("dropped edge produced a sample");
  chk_skip_off_all: assert property (
    samp_ok && !cfg_reg.skip_on && !cfg_reg.avg_on |=> out_valid)
    else $error("edge lost with skipping off");
  chk_first_clear: assert property (
    acc_wr && first_rec |=> acc_a[$past(acc_ix)] == $past(inc_a))
    else $error("accumulator carried old sum");
  chk_clocks_limit: assert property (
    scpr_reg <= `SCPR_MAX)
    else $error("clocks per record above limit");

  cov_dump_done: cover property (dump_done);
  cov_skip_raw: cover property (raw_kept && cfg_reg.skip_on);
  cov_avg_more: cover property (rec_end && cfg_reg.avg_on && !first_rec);

endmodule : samp_path_top
`default_nettype wire

// >>> design/samp_path_unused.sv
`timescale 1ns/1ps

// >>> testbench/host_sink.sv
/*
  Host transfer sink model: takes stream words, promptly or with stalls.
  Assumes one clock and an active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module host_sink (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic slow,
  output logic      out_ready
);
  logic phase_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  // Slow mode refuses every other cycle
  assign out_ready = ~slow | phase_reg;
endmodule : host_sink
`default_nettype wire

// >>> testbench/acquisition_sample_path_options_tb.sv
/*
  Self-checking bench of the sample path: registers, low bits, skipping, averaging.
  Assumes the design package, constants header and host sink model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "samp_path_consts.svh"

module acquisition_sample_path_options_tb import samp_path_pkg::*;;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        out_valid, out_ready, out_last, rec_busy, slow;
  logic [31:0] haddr, hwdata, hrdata, out_data, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  front_t      fe_in;
  cfg_t        cfg;
  int          err_count, n_tests;
  logic [31:0] exp_q[$], got_q[$];
  logic        last_q[$];
  logic [31:0] acc[4];

  samp_path_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fe(fe_in),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_last(out_last), .rec_busy(rec_busy));

  host_sink sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .out_ready(out_ready));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got_q.push_back(out_data);
      last_q.push_back(out_last);
    end
  end

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic check_word(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      err_count++;
    end
  endtask : check_word

  task automatic check_flag(string n, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %b, seen %b", n, e, g);
      err_count++;
    end
  endtask : check_flag

  task automatic ahb_xfer(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb_xfer

  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    ahb_xfer(1'b1, a, d, rd);
  endtask : reg_write

  task automatic reg_read(logic [7:0] a, logic [31:0] e);
    ahb_xfer(1'b0, a, 32'h0, rd);
    check_word("register", e, rd);
  endtask : reg_read

  // ----------------------------------------------------------------
  // Stream helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fmt(logic [13:0] c, logic [1:0] res, logic [1:0] s0,
                                      logic [1:0] s1, logic t, logic a1, logic a2);
    logic [15:0] w;
    logic [3:0]  v;
    v = {a1, a2, t, 1'b0};
    w = (res == `RES_12) ? {c[11:0], 4'h0} : (res == `RES_8) ? {c[7:0], 8'h00} : {c, 2'h0};
    w[0] = v[s0];
    w[1] = v[s1];
    return w;
  endfunction : fmt

  task automatic send_record(int n, logic [13:0] ca, logic [13:0] cb, logic [15:0] keep,
                             logic extra);
    logic [13:0] a;
    logic [13:0] b;
    fe_in.trigger <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      a = ca + 14'(i);
      b = cb + 14'(i);
      fe_in.valid <= 1'b1;
      fe_in.code_a <= a;
      fe_in.code_b <= b;
      fe_in.low_bit_src_trigger_in <= i[0];
      fe_in.aux1 <= ~i[0];
      fe_in.aux2 <= i[1];
      fe_in.trigger <= extra && i == 1;
      if (keep[i] && !cfg.avg_on) exp_q.push_back(
        {fmt(b, cfg.res, cfg.low_bit0_source, cfg.low_bit1_source, i[0], ~i[0], i[1]),
         fmt(a, cfg.res, cfg.low_bit0_source, cfg.low_bit1_source, i[0], ~i[0], i[1])});
      @(posedge hclk);
    end
    fe_in.valid <= 1'b0;
    fe_in.trigger <= 1'b0;
    repeat (3) @(posedge hclk);
    for (int k = 0; k < 200 && rec_busy !== 1'b0; k++) @(posedge hclk);
    check_flag("rec_busy", 1'b0, rec_busy);
  endtask : send_record

  task automatic check_stream();
    check_word("stream length", 32'(exp_q.size()), 32'(got_q.size()));
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      check_word("stream word", exp_q[i], got_q[i]);
      check_flag("stream last", i == exp_q.size() - 1, last_q[i]);
    end
    exp_q.delete();
    got_q.delete();
    last_q.delete();
  endtask : check_stream

  task automatic avg_run(int nrec, logic sgn, logic [13:0] ca, logic [13:0] cb);
    logic [15:0] s;
    cfg = '0;
    cfg.avg_on = 1'b1;
    cfg.avg_signed = sgn;
    reg_write(`OFS_CTRL, {22'h0, cfg});
    reg_write(`OFS_SPR, 32'h2);
    reg_write(`OFS_RPA, 32'(nrec));
    slow <= 1'b1;
    acc = '{default: 32'h0};
    for (int r = 0; r < nrec; r++) begin
      for (int i = 0; i < 4; i++) begin
        s = fmt(((i % 2) ? cb : ca) + 14'(r + i / 2), `RES_14, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0);
        acc[i] += {{16{sgn & s[15]}}, s};
      end
      send_record(2, ca + 14'(r), cb + 14'(r), 16'h0, 1'b0);
      if (r < nrec - 1) check_word("early dump", 32'h0, 32'(got_q.size()));
      if (r < nrec - 1) reg_read(`OFS_STATUS, 32'(r + 1));
    end
    for (int i = 0; i < 4; i++) exp_q.push_back(acc[i]);
    check_stream();
    slow <= 1'b0;
  endtask : avg_run

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    fe_in = '0;
    slow = 1'b0;
    cfg = '0;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reg_read(`OFS_CTRL, 32'h0);
    reg_read(`OFS_SPR, {21'h0, `SPR_RST});
    reg_read(`OFS_RPA, {8'h0, `RPA_RST});
    reg_read(`OFS_SCPR, {15'h0, `SCPR_RST});
    check_flag("hresp", 1'b0, hresp);
    reg_write(`OFS_RPA, 32'h00FFFFFF);
    reg_read(`OFS_RPA, 32'h00FFFFFF);
    reg_write(`OFS_SCPR, 32'h00010001);
    reg_read(`OFS_SCPR, 32'h00010000);
    reg_write(8'h40, 32'hFFFFFFFF);
    reg_read(8'h40, 32'h0);
    // Map of four kept clocks out of eight
    cfg.skip_on = 1'b1;
    reg_write(`OFS_CTRL, {22'h0, cfg});
    reg_write(`OFS_SCPR, 32'h8);
    reg_write(`OFS_SPR, 32'h4);
    reg_write(`OFS_MAPIDX, 32'h0);
    reg_write(`OFS_MAPDAT, 32'h000000A5);
    reg_read(`OFS_MAPIDX, 32'h1);
    fe_in.valid <= 1'b1;
    repeat (2) @(posedge hclk);
    fe_in.valid <= 1'b0;
    @(posedge hclk);
    send_record(8, 14'h0100, 14'h0200, 16'h00A5, 1'b1);
    check_stream();
    cfg.skip_on = 1'b0;
    for (int r = 0; r < 3; r++) begin
      for (int s = 0; s < 4; s++) begin
        cfg.res = 2'(r);
        cfg.low_bit0_source = 2'(s);
        cfg.low_bit1_source = 2'(3 - s);
        reg_write(`OFS_CTRL, {22'h0, cfg});
        send_record(4, 14'h1234 + 14'(s), 14'h2ABC, 16'hFFFF, 1'b0);
        check_stream();
      end
    end
    avg_run(3, 1'b0, 14'h0064, 14'h3000);
    avg_run(2, 1'b1, 14'h3FFF, 14'h2000);
    print_verdict();
  end
endmodule : acquisition_sample_path_options_tb
`default_nettype wire
